// [hw/ofd_fast_detect.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defs.svh"
module ofd_fast_detect import ofd_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`OFD_NCHAN-1:0][`OFD_SAMPLE_W-1:0] sampleIn,
    input wire logic [`OFD_NCHAN-1:0] ovrIn,
    input wire logic [`OFD_NVC-1:0] vcOvrIn,
    input wire logic [`OFD_CSB_W-1:0] ctrlBitsPerSample,
    input wire ofd_reg_req_t regReq,
    output logic [`OFD_DATA_W-1:0] regRdData,
    output logic regRdValid,
    output logic [`OFD_NCHAN-1:0][`OFD_SAMPLE_W-1:0] sampleOut,
    output logic [`OFD_NCHAN-1:0] linkCtrlBit,
    output logic fastFlagChanA,
    output logic fastFlagChanB
);
    localparam int Lat = `OFD_SAMPLE_LAT;
    localparam int Nch = `OFD_NCHAN;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // magnitude keeps 14 bits so the most negative code reads as full scale
    function automatic logic [`OFD_SAMPLE_W-1:0] absMag(input logic [`OFD_SAMPLE_W-1:0] s);
        absMag = s[`OFD_SAMPLE_W-1] ? (~s + 1'b1) : s;
    endfunction : absMag

    function automatic logic [`OFD_SAMPLE_W-1:0] widen(input logic [`OFD_THR_W-1:0] t);
        widen = {1'b0, t};
    endfunction : widen

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [`OFD_THR_W-1:0] upperThr_q;
    logic [`OFD_THR_W-1:0] lowerThr_q;
    logic [`OFD_DWELL_W-1:0] dwell_q;
    logic [`OFD_NVC-1:0] ovrClr_q;
    logic [`OFD_NVC-1:0] sticky_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            upperThr_q <= `OFD_RST_UPPER;
            lowerThr_q <= `OFD_RST_LOWER;
            dwell_q <= `OFD_RST_DWELL;
            ovrClr_q <= `OFD_RST_BYTE;
        end else if (regReq.wrEn) begin
            case (regReq.addr)
                `OFD_ADR_UPPER_LO: upperThr_q[7:0] <= regReq.wdata;
                `OFD_ADR_UPPER_HI: upperThr_q[`OFD_THR_W-1:8] <= regReq.wdata[`OFD_THR_HI_W-1:0];
                `OFD_ADR_LOWER_LO: lowerThr_q[7:0] <= regReq.wdata;
                `OFD_ADR_LOWER_HI: lowerThr_q[`OFD_THR_W-1:8] <= regReq.wdata[`OFD_THR_HI_W-1:0];
                `OFD_ADR_DWELL_LO: dwell_q[7:0] <= regReq.wdata;
                `OFD_ADR_DWELL_HI: dwell_q[15:8] <= regReq.wdata;
                `OFD_ADR_OVR_CLR: ovrClr_q <= regReq.wdata;
                default: ;
            endcase
        end
    end

    // unmapped and write-only-free reads answer zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdValid <= 1'b0;
            regRdData <= `OFD_RST_BYTE;
        end else begin
            regRdValid <= regReq.rdEn;
            if (regReq.rdEn) begin
                case (regReq.addr)
                    `OFD_ADR_UPPER_LO: regRdData <= upperThr_q[7:0];
                    `OFD_ADR_UPPER_HI: regRdData <= {3'h0, upperThr_q[`OFD_THR_W-1:8]};
                    `OFD_ADR_LOWER_LO: regRdData <= lowerThr_q[7:0];
                    `OFD_ADR_LOWER_HI: regRdData <= {3'h0, lowerThr_q[`OFD_THR_W-1:8]};
                    `OFD_ADR_DWELL_LO: regRdData <= dwell_q[7:0];
                    `OFD_ADR_DWELL_HI: regRdData <= dwell_q[15:8];
                    `OFD_ADR_OVR_CLR: regRdData <= ovrClr_q;
                    `OFD_ADR_OVR_STS: regRdData <= sticky_q;
                    default: regRdData <= `OFD_RST_BYTE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // sticky overrange per virtual converter
    // ----------------------------------------
    // clear is level sensitive while the bit is one; a new event still wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sticky_q <= `OFD_RST_BYTE;
        end else begin
            sticky_q <= (sticky_q & ~ovrClr_q) | vcOvrIn;
        end
    end

    // ----------------------------------------
    // sample and overrange alignment
    // ----------------------------------------
    logic [Nch-1:0][Lat-2:0][`OFD_SAMPLE_W-1:0] sampleDly_q;
    logic [Nch-1:0][Lat-2:0] ovrDly_q;
    logic csbOn;

    assign csbOn = (ctrlBitsPerSample != '0);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sampleDly_q <= '0;
            ovrDly_q <= '0;
            sampleOut <= '0;
            linkCtrlBit <= '0;
        end else begin
            for (int c = 0; c < Nch; c++) begin
                sampleDly_q[c][0] <= sampleIn[c];
                ovrDly_q[c][0] <= ovrIn[c];
                for (int k = 1; k < Lat - 1; k++) begin
                    sampleDly_q[c][k] <= sampleDly_q[c][k-1];
                    ovrDly_q[c][k] <= ovrDly_q[c][k-1];
                end
                sampleOut[c] <= sampleDly_q[c][Lat-2];
                linkCtrlBit[c] <= ovrDly_q[c][Lat-2] & csbOn;
            end
        end
    end

    // ----------------------------------------
    // fast detect, two comparators (upper and lower) per channel
    // ----------------------------------------
    logic [Nch-1:0][`OFD_SAMPLE_W-1:0] magQ;
    logic [Nch-1:0][`OFD_SAMPLE_W-1:0] lateMag;
    logic [Nch-1:0] aboveUp;
    logic [Nch-1:0] belowLow;
    logic [Nch-1:0][`OFD_DWELL_W-1:0] dwellCnt_q;
    ofd_fd_state_t fdState_q [Nch];
    logic [`OFD_DWELL_W-1:0] dwellLim;

    // zero is out of range; treated as the shortest dwell
    assign dwellLim = (dwell_q == '0) ? `OFD_DWELL_MIN : dwell_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            magQ <= '0;
        end else begin
            for (int c = 0; c < Nch; c++) begin
                magQ[c] <= absMag(sampleIn[c]);
            end
        end
    end

    // upper path uses the early magnitude for latency; lower path the aligned one
    always_comb begin
        for (int c = 0; c < Nch; c++) begin
            lateMag[c] = absMag(sampleDly_q[c][Lat-2]);
            aboveUp[c] = magQ[c] > widen(upperThr_q);
            belowLow[c] = lateMag[c] < widen(lowerThr_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int c = 0; c < Nch; c++) begin
                fdState_q[c] <= OFD_FD_CLEAR;
                dwellCnt_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < Nch; c++) begin
                unique case (fdState_q[c])
                    OFD_FD_CLEAR: begin
                        dwellCnt_q[c] <= '0;
                        if (aboveUp[c]) begin
                            fdState_q[c] <= OFD_FD_DETECT;
                        end
                    end
                    OFD_FD_DETECT: begin
                        if (aboveUp[c] || !belowLow[c]) begin
                            dwellCnt_q[c] <= '0;
                        end else if (dwellCnt_q[c] >= dwellLim) begin
                            fdState_q[c] <= OFD_FD_CLEAR;
                            dwellCnt_q[c] <= '0;
                        end else begin
                            dwellCnt_q[c] <= dwellCnt_q[c] + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign fastFlagChanA = (fdState_q[0] == OFD_FD_DETECT);
    assign fastFlagChanB = (fdState_q[1] == OFD_FD_DETECT);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [Nch-1:0] fdFlag;
    logic [3:0] warm_q;

    assign fdFlag = {fastFlagChanB, fastFlagChanA};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            warm_q <= '0;
        end else if (warm_q != 4'hF) begin
            warm_q <= warm_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    for (genvar g = 0; g < Nch; g++) begin : g_chk
        sequence s_cross;
            (absMag(sampleIn[g]) > widen(upperThr_q)) && !regReq.wrEn ##1 !regReq.wrEn;
        endsequence

        property p_fast_set;
            aboveUp[g] |=> fdFlag[g];
        endproperty
        a_fast_set: assert property (p_fast_set) else $error("fast flag missed");

        property p_fast_latency;
            s_cross |-> ##[0:27] fdFlag[g];
        endproperty
        a_fast_latency: assert property (p_fast_latency) else $error("flag too late");

        property p_hold;
            $fell(fdFlag[g]) |-> $past(belowLow[g]) && !$past(aboveUp[g])
                && ($past(dwellCnt_q[g]) >= $past(dwellLim));
        endproperty
        a_hold: assert property (p_hold) else $error("flag cleared early");

        property p_restart;
            fdFlag[g] && !belowLow[g] |=> dwellCnt_q[g] == '0;
        endproperty
        a_restart: assert property (p_restart) else $error("dwell not restarted");

        property p_link_align;
            warm_q == 4'hF |-> linkCtrlBit[g] == ($past(ovrIn[g], Lat) & $past(csbOn));
        endproperty
        a_link_align: assert property (p_link_align) else $error("link bit misaligned");
    end

    property p_sticky_set;
        vcOvrIn != '0 |=> (sticky_q & $past(vcOvrIn)) == $past(vcOvrIn);
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");

    property p_sticky_keep;
        1'b1 |=> (sticky_q & $past(sticky_q & ~ovrClr_q)) == $past(sticky_q & ~ovrClr_q);
    endproperty
    a_sticky_keep: assert property (p_sticky_keep) else $error("sticky lost");

    property p_reg_upper;
        regReq.wrEn && regReq.addr == `OFD_ADR_UPPER_LO |=> upperThr_q[7:0] == $past(regReq.wdata);
    endproperty
    a_reg_upper: assert property (p_reg_upper) else $error("upper write lost");

    property p_reg_dwell;
        regReq.wrEn && regReq.addr == `OFD_ADR_DWELL_HI |=> dwell_q[15:8] == $past(regReq.wdata);
    endproperty
    a_reg_dwell: assert property (p_reg_dwell) else $error("dwell write lost");

    property p_rd_status;
        regReq.rdEn && regReq.addr == `OFD_ADR_OVR_STS |=> regRdValid && regRdData == $past(sticky_q);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");
endmodule : ofd_fast_detect
`default_nettype wire

// [hw/ofd_defs.svh]
`ifndef OFD_DEFS_SVH
`define OFD_DEFS_SVH
// ----------------------------------------
// widths and depths
// ----------------------------------------
`define OFD_NCHAN 2
`define OFD_SAMPLE_W 14
`define OFD_THR_W 13
`define OFD_THR_HI_W 5
`define OFD_DWELL_W 16
`define OFD_NVC 8
`define OFD_CSB_W 2
`define OFD_ADDR_W 16
`define OFD_DATA_W 8
`define OFD_SAMPLE_LAT 9
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFD_ADR_UPPER_LO 16'h0247
`define OFD_ADR_UPPER_HI 16'h0248
`define OFD_ADR_LOWER_LO 16'h0249
`define OFD_ADR_LOWER_HI 16'h024A
`define OFD_ADR_DWELL_LO 16'h024B
`define OFD_ADR_DWELL_HI 16'h024C
`define OFD_ADR_OVR_CLR 16'h0562
`define OFD_ADR_OVR_STS 16'h0563
// ----------------------------------------
// reset values
// ----------------------------------------
`define OFD_RST_UPPER 13'h1FFF
`define OFD_RST_LOWER 13'h0000
`define OFD_RST_DWELL 16'h0001
`define OFD_RST_BYTE 8'h00
`define OFD_DWELL_MIN 16'h0001
`endif

// [hw/ofd_pkg.sv]
`include "ofd_defs.svh"
package ofd_pkg;
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [`OFD_ADDR_W-1:0] addr;
        logic [`OFD_DATA_W-1:0] wdata;
    } ofd_reg_req_t;

    typedef enum logic [0:0] {
        OFD_FD_CLEAR = 1'b0,
        OFD_FD_DETECT = 1'b1
    } ofd_fd_state_t;
endpackage : ofd_pkg

// [dv/ofd_link_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defs.svh"
// ----------------------------------------
// link receiver: keeps chan A sample framed with its ctrl bit
// ----------------------------------------
module ofd_link_rx_model (
    input wire logic clk_sys,
    input wire logic [`OFD_NCHAN-1:0][`OFD_SAMPLE_W-1:0] sampleOut,
    input wire logic [`OFD_NCHAN-1:0] linkCtrlBit,
    output logic [`OFD_SAMPLE_W-1:0] ovrSample,
    output logic [7:0] ovrCount
);
    initial ovrCount = 8'h00;
    always @(posedge clk_sys) begin
        if (linkCtrlBit[0] === 1'b1) begin
            ovrSample <= sampleOut[0];
            ovrCount <= ovrCount + 8'h01;
        end
    end
endmodule : ofd_link_rx_model
`default_nettype wire

// [dv/ofd_fast_detect_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defs.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module ofd_fast_detect_tb import ofd_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0][13:0] sampleIn = '0;
    logic [1:0] ovrIn = '0;
    logic [7:0] vcOvrIn = '0;
    logic [1:0] ctrlBitsPerSample = '0;
    ofd_reg_req_t regReq = '0;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [1:0][13:0] sampleOut;
    logic [1:0] linkCtrlBit;
    logic fastFlagChanA;
    logic fastFlagChanB;
    logic [13:0] ovrSample;
    logic [7:0] ovrCount;
    logic [7:0] rv;
    logic [7:0] cnt;
    logic noise = 1'b1;
    int n;
    integer seed = 32'hd5bb;
    integer errCount = 0;
    integer checks = 0;
    logic [15:0] adrs [9] = '{16'h0247, 16'h0248, 16'h0249, 16'h024A, 16'h024B,
        16'h024C, 16'h0562, 16'h0563, 16'h0300};
    logic [7:0] rstv [9] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    ofd_fast_detect dut (.clk_sys(clk_sys), .rst_n(rst_n), .sampleIn(sampleIn),
        .ovrIn(ovrIn), .vcOvrIn(vcOvrIn), .ctrlBitsPerSample(ctrlBitsPerSample),
        .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
        .sampleOut(sampleOut), .linkCtrlBit(linkCtrlBit),
        .fastFlagChanA(fastFlagChanA), .fastFlagChanB(fastFlagChanB));
    ofd_link_rx_model rx (.clk_sys(clk_sys), .sampleOut(sampleOut),
        .linkCtrlBit(linkCtrlBit), .ovrSample(ovrSample), .ovrCount(ovrCount));
    always #12.5 clk_sys = ~clk_sys;
    // small background samples, below the 0x100 lower threshold that the test sets
    always @(posedge clk_sys) begin
        if (noise) begin
            sampleIn[0] <= 14'($random(seed)) & 14'h00FF;
            sampleIn[1] <= 14'($random(seed)) & 14'h00FF;
            // chan B overrange only exercised through the alignment check
            ovrIn[1] <= 1'($random(seed));
        end
    end
    // threshold high bytes keep five bits
    function automatic logic [7:0] expRd(input int i, input logic [7:0] v);
        expRd = (i == 1 || i == 3) ? (v & 8'h1F) : v;
    endfunction : expRd
    function automatic logic [15:0] expLink(input int k);
        expLink = (k != 0) ? 16'h0001 : 16'h0000;
    endfunction : expLink
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        regReq <= '0;
    endtask : wr
    task rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
        chk({15'h0, regRdValid}, 16'h0001);
        chk({8'h00, regRdData}, {8'h00, exp});
    endtask : rdc
    task flagWait(input logic want, input int lim);
        n = 0;
        while (fastFlagChanA !== want && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : flagWait
    task conclude;
        if (errCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #2000000;
        errCount++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) rdc(adrs[i], rstv[i]);
        for (int i = 0; i < 6; i++) begin
            rv = 8'($random(seed));
            wr(adrs[i], rv);
            rdc(adrs[i], expRd(i, rv));
        end
        wr(`OFD_ADR_OVR_STS, 8'hFF);
        rdc(`OFD_ADR_OVR_STS, 8'h00);
        // upper 0x800, lower 0x100, dwell 10
        wr(`OFD_ADR_UPPER_LO, 8'h00);
        wr(`OFD_ADR_UPPER_HI, 8'h08);
        wr(`OFD_ADR_LOWER_LO, 8'h00);
        wr(`OFD_ADR_LOWER_HI, 8'h01);
        wr(`OFD_ADR_DWELL_LO, 8'h0A);
        wr(`OFD_ADR_DWELL_HI, 8'h00);
        flagWait(1'b0, 200);
        chk(fastFlagChanA, 1'b0);
        noise <= 1'b0;
        @(posedge clk_sys);
        sampleIn[0] <= 14'h0800;
        repeat (30) @(posedge clk_sys);
        #1;
        chk(fastFlagChanA, 1'b0);
        @(posedge clk_sys);
        sampleIn[0] <= 14'h37FF;
        @(posedge clk_sys);
        sampleIn[0] <= 14'h0010;
        flagWait(1'b1, 28);
        chk(fastFlagChanA, 1'b1);
        chk(fastFlagChanB, 1'b0);
        // spike must land inside the dwell window so the restart is what keeps the flag
        repeat (5) @(posedge clk_sys);
        sampleIn[0] <= 14'h0100;
        @(posedge clk_sys);
        sampleIn[0] <= 14'h0010;
        repeat (14) @(posedge clk_sys);
        #1;
        chk(fastFlagChanA, 1'b1);
        flagWait(1'b0, 20);
        chk({15'h0, fastFlagChanA}, 16'h0000);
        chk(n > 0, 1'b1);
        @(posedge clk_sys);
        sampleIn[1] <= 14'h0FFF;
        repeat (28) @(posedge clk_sys);
        #1;
        chk(fastFlagChanB, 1'b1);
        noise <= 1'b1;
        for (int k = 3; k >= 0; k--) begin
            cnt = ovrCount;
            @(posedge clk_sys);
            noise <= 1'b0;
            ctrlBitsPerSample <= 2'(k);
            @(posedge clk_sys);
            sampleIn[0] <= 14'h0155;
            ovrIn[0] <= 1'b1;
            @(posedge clk_sys);
            noise <= 1'b1;
            ovrIn[0] <= 1'b0;
            repeat (14) @(posedge clk_sys);
            chk(8'(ovrCount - cnt), expLink(k));
            if (k != 0) chk(ovrSample, 14'h0155);
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            vcOvrIn <= 8'h01 << k;
            @(posedge clk_sys);
            vcOvrIn <= 8'h00;
            rdc(`OFD_ADR_OVR_STS, 8'h01 << k);
            wr(`OFD_ADR_OVR_CLR, 8'h01 << k);
            wr(`OFD_ADR_OVR_CLR, 8'h00);
            rdc(`OFD_ADR_OVR_STS, 8'h00);
        end
        conclude();
    end
endmodule : ofd_fast_detect_tb
`default_nettype wire
